/* File: design/lbp_params.svh */
// Register offsets, field positions and timing counts of the local bus port
`ifndef LBP_PARAMS_SVH
`define LBP_PARAMS_SVH
`define OFS_CTRL 8'h00
`define OFS_MADDR 8'h04
`define OFS_MCMD 8'h08
`define OFS_STATUS 8'h0C
`define OFS_SADDR 8'h10
`define OFS_SINFO 8'h14
`define CTRL_SWRST 0
`define CTRL_M68K 1
`define CTRL_ASYNC 2
`define ST_MBUSY 0
`define ST_DONE 1
`define ST_ERR 2
`define ST_RETRY 3
`define ST_BADSIZE 4
`define ST_BMEN 5
`define ST_STRAP_LO 6
`define SEL_WAIT 2'h3
`define SIZE_4B 2'h0
`define SIZE_1B 2'h1
`define SIZE_2B 2'h2
`define SIZE_3B 2'h3
`define SIZE_RSVD 2'h3
`define TERM_ACK 2'h0
`define TERM_ERR 2'h1
`define TERM_RETRY 2'h2
`endif

/* File: design/lbp_pkg.sv */
// Types shared by the local bus port and its user side
package lbp_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SEL = 3'b001,
    S_WAIT = 3'b010,
    S_TERM = 3'b011,
    S_NEG = 3'b100
  } slv_state_t;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_REQ = 3'b001,
    M_OWN = 3'b010,
    M_START = 3'b011,
    M_DATA = 3'b100,
    M_REL = 3'b101
  } mst_state_t;
  typedef struct packed {
    logic reg_sel;
    logic image;
    logic dma;
    logic rd;
    logic [1:0] size;
    logic [3:0] lanes;
    logic [3:0] tc;
    logic [11:0] reg_offset;
    logic [31:0] addr;
  } slv_req_t;
  typedef struct packed {
    logic done;
    logic err;
    logic retry;
  } slv_resp_t;
endpackage

/* File: design/local_bus_port.sv */
// Local processor bus port: slave decode and termination, master cycles, arbitration, straps
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "lbp_params.svh"

// Notes on behaviour
// [RL1] As slave, every normal cycle ends with transfer acknowledge asserted.
// [RL2] Start, acknowledge, retry, busy and error are driven high before release.
// [RL3] Slave retry uses exactly the acknowledge timing slot.
// [RL4] In 68k mode retry is acknowledge plus error acknowledge together.
// [RL5] Master drives start low after an edge; address group valid next edge.
// [RL6] Slave samples start on edges and captures address on that edge.
// [RL7] Window or register select may come on the start edge or three later.
// [RL8] Image choice picks the slave image while the window select is asserted.
// [RL9] Register offset uses only the lowest twelve address bits.
// [RL10] Size: 00 four, 01 one, 10 two, 11 three as slave, never driven.
// [RL11] Byte lanes come from size, two low address bits and port width.
// [RL12] In embedded mode slave captures transfer code one edge after start.
// [RL13] Master drives programmed transfer code with address timing, else released.
// [RL14] Other masters present an all-ones transfer code for DMA transfers.
// [RL15] Direction high for read; driven only as master, input as slave.
// [RL16] Request changes on edges; grant sampled on edges or synchronised async.
// [RL17] Busy asserted while owner, negated before release, sampled as input.
// [RL18] Slave drives error acknowledge; master samples target error on edges.
// [RL19] In 68k mode burst pin and upper size bit are latched at reset.
// [RL20] Master-enable strap high during PCI reset sets bus master enable.
// [RL21] Local reset output asserted on PCI reset or software reset bit.
// [RL22] Local reset input leaves PCI configuration and status bits unchanged.
// [RL23] Transfer start is asserted for exactly one clock.
module local_bus_port
  import lbp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic pci_rst_n,
  input wire logic local_reset_in_n,
  output logic local_reset_out_o,
  output logic local_reset_out_oe,
  input wire logic master_en_strap,
  input wire logic burst_in_progress_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] addr_i,
  output logic [31:0] addr_o,
  input wire logic [3:0] xfer_code_i,
  output logic [3:0] xfer_code_o,
  input wire logic [1:0] size_code_i,
  output logic [1:0] size_code_o,
  input wire logic rd_wr_i,
  output logic rd_wr_o,
  output logic addr_grp_oe,
  input wire logic xfer_start_n_i,
  output logic xfer_start_n_o,
  output logic xfer_start_oe,
  input wire logic xfer_ack_n_i,
  output logic xfer_ack_n_o,
  input wire logic xfer_error_ack_n_i,
  output logic xfer_error_ack_n_o,
  output logic xfer_retry_n_o,
  input wire logic xfer_retry_n_i,
  output logic term_oe,
  output logic arb_request_n,
  input wire logic arb_grant_n,
  input wire logic arb_owner_busy_n_i,
  output logic arb_owner_busy_n_o,
  output logic arb_owner_busy_oe,
  input wire logic pci_window_select_n,
  input wire logic regs_select_n,
  input wire logic image_choice,
  input wire logic dma_ack_in_n,
  output slv_req_t slv_req,
  output logic slv_req_valid,
  input wire slv_resp_t slv_resp
);

  // Active byte lanes on a 32-bit port
  function automatic logic [3:0] lanes_of(input logic [1:0] sz, input logic [1:0] a);
    logic [3:0] base;
    base = 4'hF;
    if (sz == `SIZE_1B) begin
      base = 4'h1;
    end else if (sz == `SIZE_2B) begin
      base = 4'h3;
    end else if (sz == `SIZE_3B) begin
      base = 4'h7;
    end
    return (sz == `SIZE_4B) ? 4'hF : 4'((base << a) & 4'hF);
  endfunction

  logic sw_reset_reg;
  logic m68k_reg;
  logic async_arb_reg;
  logic [31:0] maddr_reg;
  logic [3:0] mtc_reg;
  logic [1:0] msize_reg;
  logic mrd_reg;
  logic done_reg;
  logic err_reg;
  logic retry_reg;
  logic badsize_reg;
  logic master_en_strap_reg;
  logic [1:0] strap_reg;
  logic [31:0] reg_rdata_reg;
  slv_state_t slv_state_reg;
  slv_state_t slv_state_next;
  mst_state_t mst_state_reg;
  mst_state_t mst_state_next;
  logic [1:0] wcnt_reg;
  logic hit_pci_reg;
  logic hit_reg_reg;
  logic [1:0] term_reg;
  slv_req_t cap_reg;
  slv_req_t slv_req_reg;
  logic slv_req_valid_reg;
  logic grant_s1_reg;
  logic grant_s2_reg;

  // Port-side reset: local reset input only; power reset comes from arst_n
  wire port_rst = !local_reset_in_n;
  wire wr_ctrl = reg_wr && (reg_addr == `OFS_CTRL);
  wire wr_maddr = reg_wr && (reg_addr == `OFS_MADDR);
  wire wr_mcmd = reg_wr && (reg_addr == `OFS_MCMD);
  wire wr_status = reg_wr && (reg_addr == `OFS_STATUS);
  wire go = wr_mcmd && reg_wdata[7];
  wire go_ok = go && (reg_wdata[5:4] != `SIZE_RSVD); // RL10
  wire go_bad = go && (reg_wdata[5:4] == `SIZE_RSVD); // RL10
  wire ts_seen = !xfer_start_n_i; // RL6
  wire pci_any = hit_pci_reg || !pci_window_select_n; // RL7
  wire reg_any = hit_reg_reg || !regs_select_n; // RL7
  wire tc_now = (m68k_reg || wcnt_reg != 2'h0); // RL12
  wire grant = async_arb_reg ? grant_s2_reg : !arb_grant_n; // RL16
  wire bus_free = arb_owner_busy_n_i; // RL17
  wire t_ack = !xfer_ack_n_i;
  wire t_err = !xfer_error_ack_n_i;
  wire t_retry = m68k_reg ? (t_ack && t_err) : !xfer_retry_n_i; // RL4
  wire t_any = t_ack || t_err || t_retry;
  wire set_done = (mst_state_reg == M_DATA) && t_ack && !t_retry;
  wire set_err = (mst_state_reg == M_DATA) && t_err && !t_retry; // RL18
  wire set_retry = (mst_state_reg == M_DATA) && t_retry; // RL4
  wire mst_own = (mst_state_reg != M_IDLE) && (mst_state_reg != M_REQ);

  // Reset output: PCI reset or software reset, open drain
  assign local_reset_out_o = 1'b0;
  assign local_reset_out_oe = !pci_rst_n || sw_reset_reg; // RL21

  // Control registers written by software
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_reset_reg <= 1'b0;
      m68k_reg <= 1'b0;
      async_arb_reg <= 1'b0;
      maddr_reg <= 32'h0000_0000;
      mtc_reg <= 4'h0;
      msize_reg <= 2'h0;
      mrd_reg <= 1'b0;
    end else if (port_rst) begin
      sw_reset_reg <= 1'b0;
      m68k_reg <= 1'b0;
      async_arb_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        sw_reset_reg <= reg_wdata[`CTRL_SWRST];
        m68k_reg <= reg_wdata[`CTRL_M68K];
        async_arb_reg <= reg_wdata[`CTRL_ASYNC];
      end
      if (wr_maddr) begin
        maddr_reg <= reg_wdata;
      end
      if (go_ok && mst_state_reg == M_IDLE) begin
        mtc_reg <= reg_wdata[3:0]; // RL13
        msize_reg <= reg_wdata[5:4];
        mrd_reg <= reg_wdata[6];
      end
    end
  end

  // Sticky master results, write one to clear; a new event wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      retry_reg <= 1'b0;
      badsize_reg <= 1'b0;
    end else if (port_rst) begin
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      retry_reg <= 1'b0;
      badsize_reg <= 1'b0;
    end else begin
      done_reg <= set_done || (done_reg && !(wr_status && reg_wdata[`ST_DONE]));
      err_reg <= set_err || (err_reg && !(wr_status && reg_wdata[`ST_ERR]));
      retry_reg <= set_retry || (retry_reg && !(wr_status && reg_wdata[`ST_RETRY]));
      badsize_reg <= go_bad || (badsize_reg && !(wr_status && reg_wdata[`ST_BADSIZE]));
    end
  end

  // Straps: master enable under PCI reset only, mode pins under local reset in 68k mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      master_en_strap_reg <= 1'b0;
      strap_reg <= 2'h0;
    end else begin
      if (!pci_rst_n && master_en_strap) begin
        master_en_strap_reg <= 1'b1; // RL20 RL22
      end
      if (port_rst && m68k_reg) begin
        strap_reg <= {burst_in_progress_n, size_code_i[1]}; // RL19
      end
    end
  end

  // Register read data, one cycle after the strobe; unmapped reads zero
  wire [31:0] rd_mux =
    (reg_addr == `OFS_CTRL) ? {29'h0, async_arb_reg, m68k_reg, sw_reset_reg} :
    (reg_addr == `OFS_MADDR) ? maddr_reg :
    (reg_addr == `OFS_MCMD) ? {25'h0, mrd_reg, msize_reg, mtc_reg} :
    (reg_addr == `OFS_STATUS) ? {24'h0, strap_reg, master_en_strap_reg, badsize_reg,
                                 retry_reg, err_reg, done_reg, mst_own} :
    (reg_addr == `OFS_SADDR) ? cap_reg.addr :
    (reg_addr == `OFS_SINFO) ? {16'h0, cap_reg.tc, cap_reg.lanes, cap_reg.size,
                                cap_reg.rd, cap_reg.dma, cap_reg.image, cap_reg.reg_sel,
                                2'h0} :
    32'h0000_0000;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_reg <= 32'h0000_0000;
    end else begin
      reg_rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end
  assign reg_rdata = reg_rdata_reg;

  // Slave sequencer
  always_comb begin
    slv_state_next = slv_state_reg;
    case (slv_state_reg)
      S_IDLE: begin
        if (ts_seen && !mst_own) begin
          slv_state_next = S_SEL;
        end
      end
      S_SEL: begin
        if (reg_any) begin
          slv_state_next = S_TERM;
        end else if (pci_any) begin
          slv_state_next = S_WAIT;
        end else if (wcnt_reg == (`SEL_WAIT - 2'h1)) begin
          slv_state_next = S_IDLE; // RL7
        end
      end
      S_WAIT: begin
        if (slv_resp.done || slv_resp.err || slv_resp.retry) begin
          slv_state_next = S_TERM;
        end
      end
      S_TERM: begin
        slv_state_next = S_NEG;
      end
      default: begin
        slv_state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      slv_state_reg <= S_IDLE;
      wcnt_reg <= 2'h0;
      hit_pci_reg <= 1'b0;
      hit_reg_reg <= 1'b0;
      term_reg <= `TERM_ACK;
      cap_reg <= '0;
      slv_req_reg <= '0;
      slv_req_valid_reg <= 1'b0;
    end else if (port_rst) begin
      slv_state_reg <= S_IDLE;
      slv_req_valid_reg <= 1'b0;
    end else begin
      slv_state_reg <= slv_state_next;
      slv_req_valid_reg <= 1'b0;
      if (slv_state_reg == S_IDLE && ts_seen && !mst_own) begin
        cap_reg.addr <= addr_i; // RL6
        cap_reg.reg_offset <= addr_i[11:0]; // RL9
        cap_reg.size <= size_code_i; // RL10
        cap_reg.lanes <= lanes_of(size_code_i, addr_i[1:0]); // RL11
        cap_reg.rd <= rd_wr_i; // RL15
        cap_reg.image <= image_choice; // RL8
        cap_reg.dma <= !dma_ack_in_n;
        cap_reg.tc <= xfer_code_i;
        wcnt_reg <= 2'h0;
        hit_pci_reg <= !pci_window_select_n;
        hit_reg_reg <= !regs_select_n;
      end
      if (slv_state_reg == S_SEL) begin
        wcnt_reg <= wcnt_reg + 2'h1;
        if (!m68k_reg && wcnt_reg == 2'h0) begin
          cap_reg.tc <= xfer_code_i; // RL12
        end
        if (reg_any || pci_any) begin
          slv_req_reg <= cap_reg;
          slv_req_reg.reg_sel <= reg_any;
          slv_req_reg.tc <= tc_now ? cap_reg.tc : xfer_code_i;
          cap_reg.reg_sel <= reg_any;
          slv_req_valid_reg <= 1'b1;
          term_reg <= `TERM_ACK; // RL1
        end
      end
      if (slv_state_reg == S_WAIT) begin
        if (slv_resp.retry) begin
          term_reg <= `TERM_RETRY;
        end else if (slv_resp.err) begin
          term_reg <= `TERM_ERR;
        end else begin
          term_reg <= `TERM_ACK;
        end
      end
    end
  end
  assign slv_req = slv_req_reg;
  assign slv_req_valid = slv_req_valid_reg;

  // Slave termination pins: one asserted cycle, one negated cycle, release
  wire in_term = (slv_state_reg == S_TERM);
  assign term_oe = in_term || (slv_state_reg == S_NEG); // RL2
  assign xfer_ack_n_o = !(in_term && (term_reg == `TERM_ACK ||
                          (m68k_reg && term_reg == `TERM_RETRY))); // RL1 RL4
  assign xfer_retry_n_o = !(in_term && !m68k_reg && term_reg == `TERM_RETRY); // RL3
  assign xfer_error_ack_n_o = !(in_term && (term_reg == `TERM_ERR ||
                                (m68k_reg && term_reg == `TERM_RETRY))); // RL18 RL4

  // Grant synchroniser for the asynchronous arbitration mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      grant_s1_reg <= 1'b0;
      grant_s2_reg <= 1'b0;
    end else begin
      grant_s1_reg <= !arb_grant_n;
      grant_s2_reg <= grant_s1_reg; // RL16
    end
  end

  // Master sequencer
  always_comb begin
    mst_state_next = mst_state_reg;
    case (mst_state_reg)
      M_IDLE: begin
        if (go_ok && master_en_strap_reg) begin
          mst_state_next = M_REQ;
        end
      end
      M_REQ: begin
        if (grant && bus_free && slv_state_reg == S_IDLE) begin
          mst_state_next = m68k_reg ? M_START : M_OWN; // RL17
        end
      end
      M_OWN: begin
        mst_state_next = M_START;
      end
      M_START: begin
        mst_state_next = M_DATA; // RL23
      end
      M_DATA: begin
        if (t_any) begin
          mst_state_next = M_REL;
        end
      end
      default: begin
        mst_state_next = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mst_state_reg <= M_IDLE;
    end else if (port_rst) begin
      mst_state_reg <= M_IDLE;
    end else begin
      mst_state_reg <= mst_state_next;
    end
  end

  // Master pins, all changing from the state and command flops after a rising edge
  assign arb_request_n = !(mst_state_reg == M_REQ); // RL16
  assign arb_owner_busy_oe = mst_own; // RL2
  assign arb_owner_busy_n_o = (mst_state_reg == M_REL); // RL17
  assign xfer_start_oe = (mst_state_reg == M_START) || (mst_state_reg == M_DATA); // RL2
  assign xfer_start_n_o = !(mst_state_reg == M_START); // RL5 RL23
  assign addr_grp_oe = (mst_state_reg == M_START) || (mst_state_reg == M_DATA); // RL13 RL15
  assign addr_o = maddr_reg; // RL5
  assign xfer_code_o = mtc_reg; // RL13
  assign size_code_o = msize_reg; // RL10
  assign rd_wr_o = mrd_reg; // RL15

endmodule

/* File: tb/lbp_assertions.sv */
// Concurrent checks on the local bus port pins
`timescale 1ns/1ps
module lbp_checker
  import lbp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [31:0] addr_o,
  input wire logic [3:0] xfer_code_o,
  input wire logic [1:0] size_code_o,
  input wire logic addr_grp_oe,
  input wire logic xfer_start_n_o,
  input wire logic xfer_start_oe,
  input wire logic xfer_ack_n_o,
  input wire logic xfer_error_ack_n_o,
  input wire logic xfer_retry_n_o,
  input wire logic term_oe,
  input wire logic arb_owner_busy_n_o,
  input wire logic arb_owner_busy_oe,
  input wire slv_req_t slv_req,
  input wire logic slv_req_valid
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // Pin activity and expected byte lanes
  wire t_act = term_oe && !(xfer_ack_n_o && xfer_error_ack_n_o && xfer_retry_n_o);
  wire t_hi = xfer_ack_n_o && xfer_error_ack_n_o && xfer_retry_n_o;
  wire s_act = xfer_start_oe && !xfer_start_n_o;
  wire [1:0] sz = slv_req.size;
  wire [3:0] ln = (sz == 2'h0) ? 4'hF :
    ((sz == 2'h1 ? 4'h1 : sz == 2'h2 ? 4'h3 : 4'h7) << slv_req.addr[1:0]);
  AST_START_ONE: assert property (s_act |=> !s_act)
    else $error("start longer than one cycle");
  AST_TERM_NEG: assert property (t_act |=> term_oe && !t_act)
    else $error("termination not negated before release");
  AST_TERM_REL: assert property ($fell(term_oe) |-> $past(t_hi))
    else $error("termination released while low");
  AST_MST_REL: assert property ($fell(xfer_start_oe) |-> $past(xfer_start_n_o))
    else $error("start released while low");
  AST_BUSY_REL: assert property ($fell(arb_owner_busy_oe) |-> $past(arb_owner_busy_n_o))
    else $error("busy released while low");
  AST_BUSY_OWN: assert property (s_act |-> arb_owner_busy_oe && !arb_owner_busy_n_o)
    else $error("start without busy");
  AST_ADDR_HOLD: assert property (s_act |=> addr_grp_oe && $stable(addr_o) && $stable(xfer_code_o))
    else $error("address group not valid after start");
  AST_NO_RSVD: assert property (addr_grp_oe |-> size_code_o != 2'h3)
    else $error("reserved size driven");
  AST_REG_OFS: assert property (slv_req_valid && slv_req.reg_sel |-> slv_req.reg_offset == slv_req.addr[11:0])
    else $error("register offset wrong");
  AST_REG_ACK: assert property (slv_req_valid && slv_req.reg_sel |-> ##[0:1] (t_act && !xfer_ack_n_o))
    else $error("register access not acknowledged");
  AST_LANES: assert property (slv_req_valid |-> slv_req.lanes == ln)
    else $error("byte lanes wrong");
  cover property (t_act && !xfer_ack_n_o && !xfer_error_ack_n_o);
  cover property (t_act && !xfer_retry_n_o);
  cover property (s_act);
endmodule
bind local_bus_port lbp_checker chk (.sys_clk, .arst_n, .addr_o, .xfer_code_o, .size_code_o,
  .addr_grp_oe, .xfer_start_n_o, .xfer_start_oe, .xfer_ack_n_o, .xfer_error_ack_n_o,
  .xfer_retry_n_o, .term_oe, .arb_owner_busy_n_o, .arb_owner_busy_oe, .slv_req, .slv_req_valid);

/* File: tb/lbp_agent.sv */
// Far-side bus model: arbiter and target of cycles the port masters
`timescale 1ns/1ps
module lbp_agent (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic arb_request_n,
  output logic arb_grant_n,
  input wire logic busy_n,
  input wire logic start_n,
  input wire logic m68k,
  input wire logic [1:0] kind,
  input wire logic [1:0] lag,
  output logic ack_n,
  output logic err_n,
  output logic retry_n
);
  logic [1:0] cnt;
  logic armed;
  // Grant while requested and the bus is free; take it back once busy shows
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      arb_grant_n <= 1'b1;
    end else begin
      arb_grant_n <= !(!arb_request_n && busy_n);
    end
  end
  // Answer a started cycle after lag cycles for one cycle; pull-ups hold high
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {armed, cnt} <= 3'h0;
      {ack_n, err_n, retry_n} <= 3'h7;
    end else begin
      {ack_n, err_n, retry_n} <= 3'h7;
      if (!start_n) begin
        {armed, cnt} <= {1'b1, lag};
      end else if (armed && cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else if (armed) begin
        armed <= 1'b0;
        ack_n <= !(kind == 2'h0 || (kind == 2'h2 && m68k));
        err_n <= !(kind == 2'h1 || (kind == 2'h2 && m68k));
        retry_n <= !(kind == 2'h2 && !m68k);
      end
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the local bus port
`timescale 1ns/1ps
`include "lbp_params.svh"
module tb_top
  import lbp_pkg::*;
;
  logic sys_clk, arst_n, pci_rst_n, local_reset_in_n, master_en_strap, burst_in_progress_n;
  logic reg_wr, reg_rd, image_choice, dma_ack_in_n, pci_window_select_n, regs_select_n;
  logic local_reset_out_o, local_reset_out_oe, rd_wr_o, addr_grp_oe, xfer_start_n_o;
  logic xfer_start_oe, xfer_ack_n_o, xfer_error_ack_n_o, xfer_retry_n_o, term_oe;
  logic arb_request_n, arb_grant_n, arb_owner_busy_n_o, arb_owner_busy_oe, slv_req_valid;
  logic p_ack_n, p_err_n, p_retry_n, t_ts_n, t_rw, m68k;
  logic [1:0] t_size, size_code_o, kind, lag;
  logic [3:0] t_tc, xfer_code_o;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, t_addr, addr_o;
  slv_req_t slv_req;
  slv_resp_t slv_resp;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  // Wire levels: whoever enables drives, otherwise the bench or a pull-up
  wire xfer_start_n_i = xfer_start_oe ? xfer_start_n_o : t_ts_n;
  wire dev_ts_n = xfer_start_oe ? xfer_start_n_o : 1'b1;
  wire [31:0] addr_i = addr_grp_oe ? addr_o : t_addr;
  wire [3:0] xfer_code_i = addr_grp_oe ? xfer_code_o : t_tc;
  wire [1:0] size_code_i = addr_grp_oe ? size_code_o : t_size;
  wire rd_wr_i = addr_grp_oe ? rd_wr_o : t_rw;
  wire xfer_ack_n_i = (term_oe ? xfer_ack_n_o : 1'b1) & p_ack_n;
  wire xfer_error_ack_n_i = (term_oe ? xfer_error_ack_n_o : 1'b1) & p_err_n;
  wire xfer_retry_n_i = (term_oe ? xfer_retry_n_o : 1'b1) & p_retry_n;
  wire arb_owner_busy_n_i = arb_owner_busy_oe ? arb_owner_busy_n_o : 1'b1;
  local_bus_port dut (.sys_clk, .arst_n, .pci_rst_n, .local_reset_in_n, .local_reset_out_o,
    .local_reset_out_oe, .master_en_strap, .burst_in_progress_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .addr_i, .addr_o, .xfer_code_i, .xfer_code_o, .size_code_i,
    .size_code_o, .rd_wr_i, .rd_wr_o, .addr_grp_oe, .xfer_start_n_i, .xfer_start_n_o,
    .xfer_start_oe, .xfer_ack_n_i, .xfer_ack_n_o, .xfer_error_ack_n_i, .xfer_error_ack_n_o,
    .xfer_retry_n_o, .xfer_retry_n_i, .term_oe, .arb_request_n, .arb_grant_n,
    .arb_owner_busy_n_i, .arb_owner_busy_n_o, .arb_owner_busy_oe, .pci_window_select_n,
    .regs_select_n, .image_choice, .dma_ack_in_n, .slv_req, .slv_req_valid, .slv_resp);
  lbp_agent far (.sys_clk, .arst_n, .arb_request_n, .arb_grant_n, .busy_n(arb_owner_busy_n_i),
    .start_n(dev_ts_n), .m68k, .kind, .lag, .ack_n(p_ack_n), .err_n(p_err_n),
    .retry_n(p_retry_n));
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Register port cycles, one strobe cycle then a settle cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
      input string what);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(what, e, reg_rdata & m);
    @(posedge sys_clk);
  endtask
  function automatic logic [3:0] lane_f(input logic [1:0] s, input logic [1:0] lo);
    lane_f = (s == 2'h0) ? 4'hF : ((s == 2'h1 ? 4'h1 : s == 2'h2 ? 4'h3 : 4'h7) << lo);
  endfunction
  // Slave cycle from the bench: start, late select, user answer, termination check
  task automatic slave(input logic rs, input int dly, input logic [1:0] resp);
    logic [31:0] a;
    logic [3:0] tc2;
    logic [2:0] ex;
    logic [1:0] s;
    logic got, done;
    a = $urandom;
    s = 2'($urandom_range(3));
    tc2 = a[29] ? 4'hF : 4'(a[7:4]);
    ex = (rs || resp == 2'h0) ? 3'h3 : (resp == 2'h1) ? 3'h5 : m68k ? 3'h1 : 3'h6;
    {got, done} = 2'h0;
    {t_addr, t_size, t_rw, image_choice, dma_ack_in_n} <= {a, s, a[31], a[30], !a[29]};
    t_tc <= m68k ? tc2 : ~tc2;
    t_ts_n <= 1'b0;
    if (dly == 0) {regs_select_n, pci_window_select_n} <= rs ? 2'h1 : 2'h2;
    for (int n = 0; n < 16 && !done; n++) begin
      @(posedge sys_clk);
      if (n == 0) {t_ts_n, t_tc, t_addr} <= {1'b1, tc2, ~a};
      if (n + 1 == dly) {regs_select_n, pci_window_select_n} <= rs ? 2'h1 : 2'h2;
      // User side answers on the edge after it saw the request
      if (got) slv_resp <= {resp == 2'h0, resp == 2'h1, resp == 2'h2};
      #1;
      if (slv_req_valid) begin
        got = 1'b1;
        chk("s_addr", a, slv_req.addr);
        chk("s_lanes", lane_f(s, a[1:0]), slv_req.lanes);
        chk("s_code", tc2, slv_req.tc);
        chk("s_info", {rs, a[30], a[29], a[31], s}, {slv_req.reg_sel, slv_req.image,
          slv_req.dma, slv_req.rd, slv_req.size});
      end
      if (term_oe && !(xfer_ack_n_o & xfer_error_ack_n_o & xfer_retry_n_o)) begin
        done = 1'b1;
        chk("s_term", ex, {xfer_ack_n_o, xfer_error_ack_n_o, xfer_retry_n_o});
      end
    end
    chk("s_answer", dly < 4 ? 2'h3 : 2'h0, {got, done});
    @(posedge sys_clk);
    {regs_select_n, pci_window_select_n, dma_ack_in_n, slv_resp} <= 6'h38;
    repeat (2) @(posedge sys_clk);
    rdc(`OFS_SADDR, 32'hFFFFFFFF, a, "s_saddr");
  endtask
  // Master cycle through the command register, answered by the far side
  task automatic master(input logic [1:0] k);
    logic [31:0] a, e;
    logic [7:0] cmd;
    int n;
    a = $urandom;
    cmd = {1'b1, a[8], 2'($urandom_range(2)), a[7:4]};
    e = 32'h2 << k;
    {kind, lag} <= {k, a[10:9]};
    wr(`OFS_STATUS, 32'h0E);
    wr(`OFS_MADDR, a);
    wr(`OFS_MCMD, {24'h0, cmd});
    for (n = 0; n < 30; n++) begin
      @(posedge sys_clk);
      #1;
      if (xfer_start_oe && !xfer_start_n_o) break;
    end
    @(posedge sys_clk);
    #1 chk("m_addr", a, addr_o);
    chk("m_start", 2'h3, {n < 30, addr_grp_oe});
    chk("m_code", cmd[6:0], {rd_wr_o, size_code_o, xfer_code_o});
    repeat (10) @(posedge sys_clk);
    chk("m_idle", 3'h0, {addr_grp_oe, xfer_start_oe, arb_owner_busy_oe});
    rdc(`OFS_STATUS, 32'hF, e, "m_status");
  endtask
  // Watchdog
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc > 30000) begin
      miscompares++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    {arst_n, pci_rst_n, local_reset_in_n, master_en_strap, burst_in_progress_n} = 5'h7;
    {reg_wr, reg_rd, image_choice, m68k, reg_addr, reg_wdata} = '0;
    {t_ts_n, t_rw, t_size, t_tc, t_addr, kind, lag} = {1'b1, 43'h0};
    {pci_window_select_n, regs_select_n, dma_ack_in_n, slv_resp} = 6'h38;
    void'($urandom(42));
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    #1 chk("rst_pins", 4'h9, {local_reset_out_oe, local_reset_out_o, term_oe, arb_request_n});
    @(posedge sys_clk);
    pci_rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk("rst_out", 1'h0, local_reset_out_oe);
    @(posedge sys_clk);
    rdc(`OFS_STATUS, 32'h20, 32'h20, "bm_enable");
    wr(`OFS_CTRL, 32'h1);
    #1 chk("sw_rst_out", 1'h1, local_reset_out_oe);
    @(posedge sys_clk);
    wr(`OFS_CTRL, 32'h2);
    rdc(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
    {burst_in_progress_n, t_size, local_reset_in_n} <= 4'h4;
    @(posedge sys_clk);
    local_reset_in_n <= 1'b1;
    @(posedge sys_clk);
    rdc(`OFS_STATUS, 32'hE0, 32'h60, "strap_keep");
    wr(`OFS_MCMD, 32'hB0);
    rdc(`OFS_STATUS, 32'h11, 32'h10, "bad_size");
    for (int i = 0; i < 24; i++) begin
      m68k <= i[0];
      wr(`OFS_CTRL, {29'h0, i[1], i[0], 1'b0});
      slave(1'b1, $urandom_range(3), 2'h0);
      slave(1'b0, i < 3 ? 3 : $urandom_range(3), 2'($urandom_range(2)));
      slave(a_bit(i), 4, 2'h0);
      master(2'($urandom_range(2)));
    end
    close_out();
  end
  function automatic logic a_bit(input int i);
    a_bit = i[2];
  endfunction
endmodule
